// ===== core/adc_one_shot_sequencer.v
// one-shot successive approximation sequencer with register port
// How it works
// R1 - software trigger: writing start flag one begins a conversion
// R2 - finished result is copied into the converted channel's result register
// R3 - software trigger: interrupt request set when the result is stored
// R4 - software trigger: start flag cleared (kept on the amplifier route) and converter halted after storing
// R5 - external trigger: falling trigger pin edge with start flag set begins conversion
// R6 - external trigger: store, request interrupt and stop on completion
// R7 - external trigger: each later falling edge starts a fresh conversion
// R8 - falling edge during a conversion restarts it from the first step
// R9 - expansion route converts expansion input 0 or 1 instead of channels
// R10 - expansion finish: store, interrupt, stop and, under software trigger, clear start together
// R11 - amplifier route: channel out via expansion 0, convert expansion 1
// R12 - amplifier route: result goes to selected channel register, interrupt set
// R13 - converter clock is source divided by four, two or one
// R14 - one of eight analog channels, zero through seven, is converted
// R15 - eight or ten bit resolution; eight bit keeps upper bits only
// R16 - sample and hold: 33 or 28 clocks, first 3 sample
// R17 - no sample and hold: 59 or 49 clocks
// R18 - trigger pin synchronised, falling edge gives one-cycle start event
// R19 - clearing start mid-conversion aborts with no result, setting the abort interrupt flag
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
module adc_one_shot_sequencer #(
  parameter RES_BITS = 10                // full converter resolution
) (
  input  wire                clk,                 // source clock, 250 mhz
  input  wire                reset_n,             // async reset, active low
  input  wire [3:0]          addr,                // register word address
  input  wire [15:0]         wdata,               // write data
  input  wire                wr,                  // write strobe
  input  wire                rd,                  // read strobe
  output reg  [15:0]         rdata,               // read data, cycle after rd
  input  wire                ext_conv_trigger_n,  // external trigger pin
  input  wire                comp_out,            // analog comparator decision
  output reg  [RES_BITS-1:0] dac_code,            // trial code to the comparator
  output reg                 sample,              // sampling switch closed
  output reg  [2:0]          analog_channel_sel,  // channel mux select
  output reg                 expansion_input_sel, // expansion pin select
  output reg                 expansion_input_0_out, // channel driven onto pin 0
  output reg                 convert_expansion,   // comparator reads expansion pin
  output wire                irq                  // level interrupt
);

`include "adc_seq_regs.vh"

// ----------------------------------------------------------------
// state encodings
// ----------------------------------------------------------------
localparam IDLE    = 2'h0;
localparam SAMPLE  = 2'h1;
localparam CONVERT = 2'h2;
localparam FINISH  = 2'h3;

// ----------------------------------------------------------------
// storage
// ----------------------------------------------------------------
reg  [`CTL_WIDTH-1:0] control;
reg  [`INT_WIDTH-1:0] int_status;
reg  [`INT_WIDTH-1:0] int_mask;
reg  [RES_BITS-1:0]   result [0:7];
reg  [RES_BITS-1:0]   exp_result;
reg  [RES_BITS-1:0]   sar;
reg  [1:0]            state;
reg  [5:0]            cycle;
reg  [3:0]            bit_idx;
wire [1:0]            next_clk_sel;
wire                  tick;
wire                  trig_fall;
wire                  start_wr;
wire                  start_clr_wr;
wire                  begin_conv;
wire                  done;
wire                  abort;
wire                  busy;
wire [1:0]            route;
wire [2:0]            chan;
wire [5:0]            total;
wire [3:0]            low_bit;
integer               i;

assign route        = control[`CTL_ROUTE_HI:`CTL_ROUTE_LO];
assign chan         = control[`CTL_CH_HI:`CTL_CH_LO];
assign busy         = (state != IDLE);
assign start_wr     = wr && addr == `ADDR_CONTROL && wdata[`CTL_START];
assign start_clr_wr = wr && addr == `ADDR_CONTROL && !wdata[`CTL_START];

// conversion length by resolution and sample-and-hold
function [5:0] conv_len;
  input res10;
  input sh;
  begin
    if (sh)
      conv_len = res10 ? `CYC_SH_10 : `CYC_SH_8;     // [R16]
    else
      conv_len = res10 ? `CYC_NOSH_10 : `CYC_NOSH_8; // [R17]
  end
endfunction

assign total   = conv_len(control[`CTL_RES10], control[`CTL_SAMPLE_HOLD]);
assign low_bit = control[`CTL_RES10] ? 4'h0 : 4'h2;  // [R15]

// ----------------------------------------------------------------
// start sources
// ----------------------------------------------------------------
// software start, or trigger edge while armed (also restarts a run)
assign begin_conv = control[`CTL_EXT_TRIG] ?
                    (trig_fall && control[`CTL_START]) :          // [R5] [R7] [R8]
                    (start_wr && !busy);                          // [R1]
assign done  = (state == FINISH);
assign abort = busy && start_clr_wr && !begin_conv;               // [R19]

// the divider realigns on the start edge itself, so it must see a
// clock select written in that same cycle, not the stale one
assign next_clk_sel = (wr && addr == `ADDR_CONTROL) ? wdata[`CTL_CLK_HI:`CTL_CLK_LO]
                                                    : control[`CTL_CLK_HI:`CTL_CLK_LO];

adc_clock_divider u_div (
  .clk     (clk),
  .reset_n (reset_n),
  .clk_sel (next_clk_sel),  // [R13]
  .restart (begin_conv),
  .tick    (tick)
);

adc_trigger_sync u_trig (
  .clk                (clk),
  .reset_n            (reset_n),
  .ext_conv_trigger_n (ext_conv_trigger_n),
  .fall               (trig_fall)
);

// ----------------------------------------------------------------
// control register and start flag
// ----------------------------------------------------------------
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    control <= `CONTROL_RESET;
  end else begin
    if (wr && addr == `ADDR_CONTROL)
      control <= wdata[`CTL_WIDTH-1:0];
    // start flag drops on completion unless external trigger or amplifier route keeps it
    if (done && !(wr && addr == `ADDR_CONTROL) &&
        !control[`CTL_EXT_TRIG] && route != `ROUTE_AMPLIFIER)
      control[`CTL_START] <= 1'b0;  // [R4] [R10]
  end
end

// ----------------------------------------------------------------
// conversion state machine
// ----------------------------------------------------------------
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    state      <= IDLE;
    cycle      <= 6'h00;
    bit_idx    <= 4'h0;
    sar        <= {RES_BITS{1'b0}};
    dac_code   <= {RES_BITS{1'b0}};
  end else begin
    // dac_code moves with sar: a copy one clock behind would let the
    // comparator judge a stale trial at the undivided converter clock
    if (begin_conv) begin
      state      <= SAMPLE;  // [R8]
      cycle      <= 6'h00;
      bit_idx    <= RES_BITS[3:0] - 4'h1;
      sar        <= {RES_BITS{1'b0}};
      dac_code   <= {RES_BITS{1'b0}};
    end else if (abort) begin
      state <= IDLE;  // [R19]
    end else begin
      case (state)
        IDLE: begin
          state <= IDLE;
        end
        SAMPLE: begin
          if (tick) begin
            cycle <= cycle + 6'h01;
            if (cycle == `CYC_SAMPLE - 6'h01) begin
              state <= CONVERT;  // [R16]
              sar[bit_idx]      <= 1'b1;
              dac_code[bit_idx] <= 1'b1;
            end
          end
        end
        CONVERT: begin
          if (tick) begin
            cycle <= cycle + 6'h01;
            // one bit decided per step, remaining clocks pad to the length
            if (bit_idx >= low_bit && bit_idx != 4'hf) begin
              sar[bit_idx]      <= comp_out;
              dac_code[bit_idx] <= comp_out;
              if (bit_idx != low_bit) begin
                sar[bit_idx-4'h1]      <= 1'b1;
                dac_code[bit_idx-4'h1] <= 1'b1;
              end
              bit_idx <= bit_idx - 4'h1;
            end
            if (cycle == total - 6'h01)
              state <= FINISH;  // [R16] [R17]
          end
        end
        FINISH: begin
          state <= IDLE;  // [R4] [R6]
        end
        default: begin
          state <= IDLE;
        end
      endcase
    end
  end
end

// ----------------------------------------------------------------
// result storage
// ----------------------------------------------------------------
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    for (i = 0; i < 8; i = i + 1)
      result[i] <= {RES_BITS{1'b0}};
    exp_result <= {RES_BITS{1'b0}};
  end else if (done) begin
    if (route == `ROUTE_EXPANSION)
      exp_result <= sar;  // [R9] [R10]
    else
      result[chan] <= sar;  // [R2] [R12] [R14]
  end
end

// ----------------------------------------------------------------
// analog routing
// ----------------------------------------------------------------
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    analog_channel_sel    <= 3'h0;
    expansion_input_sel   <= 1'b0;
    expansion_input_0_out <= 1'b0;
    convert_expansion     <= 1'b0;
    sample                <= 1'b0;
  end else begin
    analog_channel_sel <= chan;  // [R14]
    case (route)
      `ROUTE_EXPANSION: begin
        expansion_input_sel   <= control[`CTL_EXP_SEL];  // [R9]
        expansion_input_0_out <= 1'b0;
        convert_expansion     <= 1'b1;
      end
      `ROUTE_AMPLIFIER: begin
        expansion_input_sel   <= 1'b1;  // [R11]
        expansion_input_0_out <= control[`CTL_START];
        convert_expansion     <= 1'b1;
      end
      default: begin
        expansion_input_sel   <= 1'b0;
        expansion_input_0_out <= 1'b0;
        convert_expansion     <= 1'b0;
      end
    endcase
    sample   <= (state == SAMPLE);
  end
end

// ----------------------------------------------------------------
// interrupt status, write one to clear, set wins
// ----------------------------------------------------------------
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    int_status <= {`INT_WIDTH{1'b0}};
    int_mask   <= {`INT_WIDTH{1'b0}};
  end else begin
    if (wr && addr == `ADDR_INT_MASK)
      int_mask <= wdata[`INT_WIDTH-1:0];
    int_status <= (int_status &
                   ~((wr && addr == `ADDR_INT_STATUS) ? wdata[`INT_WIDTH-1:0]
                                                      : {`INT_WIDTH{1'b0}})) |
                  {abort, done};  // [R3] [R6] [R10] [R12]
  end
end

assign irq = |(int_status & int_mask);

// ----------------------------------------------------------------
// read port
// ----------------------------------------------------------------
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    rdata <= 16'h0000;
  end else if (rd) begin
    if (addr[3])
      rdata <= {{(16-RES_BITS){1'b0}}, result[addr[2:0]]};
    else begin
      case (addr)
        `ADDR_CONTROL:    rdata <= {{(16-`CTL_WIDTH){1'b0}}, control};
        `ADDR_STATUS:     rdata <= {12'h000, bit_idx[1:0], state};
        `ADDR_INT_STATUS: rdata <= {14'h0000, int_status};
        `ADDR_INT_MASK:   rdata <= {14'h0000, int_mask};
        `ADDR_EXP_RESULT: rdata <= {{(16-RES_BITS){1'b0}}, exp_result};
        default:          rdata <= 16'h0000;
      endcase
    end
  end else begin
    rdata <= 16'h0000;
  end
end

endmodule

// ===== core/adc_seq_regs.vh
// register offsets, field positions, reset values and timing counts of the sequencer
`ifndef ADC_SEQ_REGS_VH
`define ADC_SEQ_REGS_VH

// ----------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------
`define ADDR_CONTROL     4'h0
`define ADDR_STATUS      4'h1
`define ADDR_INT_STATUS  4'h2
`define ADDR_INT_MASK    4'h3
`define ADDR_RESULT_BASE 4'h8
`define ADDR_EXP_RESULT  4'h4

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTL_START        0
`define CTL_EXT_TRIG     1
`define CTL_RES10        2
`define CTL_SAMPLE_HOLD  3
`define CTL_CH_LO        4
`define CTL_CH_HI        6
`define CTL_CLK_LO       7
`define CTL_CLK_HI       8
`define CTL_ROUTE_LO     9
`define CTL_ROUTE_HI     10
`define CTL_EXP_SEL      11
`define CTL_WIDTH        12
`define CONTROL_RESET    12'h004

// ----------------------------------------------------------------
// routing and clock select encodings
// ----------------------------------------------------------------
`define ROUTE_CHANNEL    2'h0
`define ROUTE_EXPANSION  2'h1
`define ROUTE_AMPLIFIER  2'h2
`define CLK_DIV4         2'h0
`define CLK_DIV2         2'h1
`define CLK_DIV1         2'h2

// ----------------------------------------------------------------
// conversion lengths in converter clocks
// ----------------------------------------------------------------
`define CYC_SH_10        6'd33
`define CYC_SH_8         6'd28
`define CYC_NOSH_10      6'd59
`define CYC_NOSH_8       6'd49
`define CYC_SAMPLE       6'd3

// ----------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------
`define INT_DONE         0
`define INT_ABORT        1
`define INT_WIDTH        2

`endif

// ===== core/adc_clock_divider.v
// converter clock enable generator: divide by four, two or one
`timescale 1ns/10ps
module adc_clock_divider (
  input  wire       clk,      // source clock
  input  wire       reset_n,  // async reset, active low
  input  wire [1:0] clk_sel,  // divider select
  input  wire       restart,  // realign phase at conversion start
  output reg        tick      // one pulse per converter clock
);

`include "adc_seq_regs.vh"

reg [1:0] count;

// ----------------------------------------------------------------
// phase counter
// ----------------------------------------------------------------
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    count <= 2'h0;
    tick  <= 1'b0;
  end else if (restart) begin
    // phase one ahead so the first tick lands one converter clock after start
    count <= 2'h1;
    tick  <= (clk_sel == `CLK_DIV1);
  end else begin
    count <= count + 2'h1;
    case (clk_sel)  // [R13]
      `CLK_DIV4: tick <= (count == 2'h3);
      `CLK_DIV2: tick <= count[0];
      `CLK_DIV1: tick <= 1'b1;
      default:   tick <= (count == 2'h3);
    endcase
  end
end

endmodule

// ===== core/adc_trigger_sync.v
// external trigger synchroniser and falling edge detector
`timescale 1ns/10ps
module adc_trigger_sync (
  input  wire clk,                 // source clock
  input  wire reset_n,             // async reset, active low
  input  wire ext_conv_trigger_n,  // trigger pin, asynchronous
  output reg  fall                 // one-cycle pulse on high-to-low
);

reg meta;
reg s2;
reg s3;
reg level;

// ----------------------------------------------------------------
// three stages, change accepted when stages two and three agree
// ----------------------------------------------------------------
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    meta  <= 1'b1;
    s2    <= 1'b1;
    s3    <= 1'b1;
    level <= 1'b1;
    fall  <= 1'b0;
  end else begin
    meta <= ext_conv_trigger_n;
    s2   <= meta;
    s3   <= s2;
    fall <= 1'b0;
    if (s2 == s3 && s3 != level) begin
      level <= s3;
      fall  <= level & ~s3;  // [R18]
    end
  end
end

endmodule

// ===== verification/adc_seq_checker.sv
// port assertions for the one-shot sequencer
`timescale 1ns/10ps
`include "adc_seq_regs.vh"
module adc_seq_checker #(
  parameter RES_BITS = 10  // resolution
) (
  input wire                clk,                   // clock
  input wire                reset_n,               // reset
  input wire [3:0]          addr,                  // address
  input wire [15:0]         wdata,                 // write data
  input wire                wr,                    // write
  input wire                rd,                    // read
  input wire [15:0]         rdata,                 // read data
  input wire                ext_conv_trigger_n,    // trigger
  input wire                comp_out,              // decision
  input wire [RES_BITS-1:0] dac_code,              // trial code
  input wire                sample,                // sampling
  input wire [2:0]          analog_channel_sel,    // channel
  input wire                expansion_input_sel,   // pin select
  input wire                expansion_input_0_out, // channel out
  input wire                convert_expansion,     // pin convert
  input wire                irq                    // interrupt
);
  reg  [11:0] ctl;                              // last control word
  reg  [15:0] cnt;                              // cycles since sampling
  reg  [15:0] len;                              // expected length
  wire        c_wr = wr && addr == `ADDR_CONTROL; // control write

  // control copy and conversion age
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl <= `CONTROL_RESET;
      cnt <= 16'h0000;
    end else begin
      if (c_wr)
        ctl <= wdata[11:0];
      if ($rose(sample))
        cnt <= 16'h0001;
      else if (cnt != 16'hffff)
        cnt <= cnt + 16'h0001;
    end
  end

  // source clocks per conversion
  always @* begin
    if (ctl[3])
      len = {10'h000, ctl[2] ? `CYC_SH_10 : `CYC_SH_8};
    else
      len = {10'h000, ctl[2] ? `CYC_NOSH_10 : `CYC_NOSH_8};
    len = len << (2'd2 - ctl[8:7]);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence sampling;
    sample [*3] ##1 !sample;
  endsequence
  sequence halted;
    !sample [*8];
  endsequence

  rd_idle_a: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data not zero");
  mask_off_a: assert property (
    wr && addr == `ADDR_INT_MASK && wdata[1:0] == 2'b00 |=> !irq)
    else $error("irq while masked");
  sw_start_a: assert property (c_wr && wdata[1:0] == 2'b01 |-> ##[1:4] sample)
    else $error("no start on write");
  chan_sel_a: assert property (
    c_wr |-> ##2 analog_channel_sel == $past(wdata[6:4], 2))
    else $error("channel select wrong");
  amp_route_a: assert property (
    c_wr && wdata[10:9] == `ROUTE_AMPLIFIER && wdata[0]
    |-> ##2 expansion_input_0_out && convert_expansion && expansion_input_sel)
    else $error("amplifier routing wrong");
  exp_route_a: assert property (
    c_wr && wdata[10:9] == `ROUTE_EXPANSION |-> ##2 convert_expansion
    && !expansion_input_0_out && expansion_input_sel == $past(wdata[11], 2))
    else $error("expansion routing wrong");
  sample_len_a: assert property ($rose(sample) && ctl[8:7] == `CLK_DIV1 |-> sampling)
    else $error("sampling not three clocks");
  conv_len_a: assert property (
    $rose(irq) && !$past(wr) |-> cnt + 16'd2 >= len && cnt <= len + 16'd2)
    else $error("conversion length wrong");
  halt_after_a: assert property ($rose(irq) && !$past(wr) |-> halted)
    else $error("converter not halted");
  trig_start_a: assert property (
    ctl[1:0] == 2'b11 && $fell(ext_conv_trigger_n) |-> ##[2:12] sample)
    else $error("no start on trigger");
endmodule

bind adc_one_shot_sequencer adc_seq_checker #(.RES_BITS(RES_BITS)) i_chk (
  .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .ext_conv_trigger_n(ext_conv_trigger_n), .comp_out(comp_out),
  .dac_code(dac_code), .sample(sample), .analog_channel_sel(analog_channel_sel),
  .expansion_input_sel(expansion_input_sel), .irq(irq),
  .expansion_input_0_out(expansion_input_0_out), .convert_expansion(convert_expansion));

// ===== verification/adc_comparator_model.sv
// analog front end and comparator seen by the sequencer
`timescale 1ns/10ps
module adc_comparator_model (
  input  wire [79:0] ch_level,              // channel levels
  input  wire [19:0] exp_level,             // expansion levels
  input  wire [2:0]  analog_channel_sel,    // channel
  input  wire        expansion_input_sel,   // pin select
  input  wire        expansion_input_0_out, // channel out
  input  wire        convert_expansion,     // pin convert
  input  wire [9:0]  dac_code,              // trial code
  output wire        comp_out               // keep bit
);
  // mux, then unit-gain loop from pin 0 back to pin 1
  wire [9:0] ch   = ch_level[analog_channel_sel*10 +: 10];
  wire [9:0] pin1 = expansion_input_0_out ? ch : exp_level[19:10];
  wire [9:0] pin  = expansion_input_sel ? pin1 : exp_level[9:0];
  assign comp_out = dac_code <= (convert_expansion ? pin : ch);
endmodule

// ===== verification/testbench.sv
// self-checking bench for the one-shot sequencer
`timescale 1ns/10ps
`include "adc_seq_regs.vh"
module testbench;
  reg         clk = 1'b0;                // clock
  reg         reset_n = 1'b0;            // reset
  reg  [3:0]  addr = 4'h0;               // address
  reg  [15:0] wdata = 16'h0000;          // write data
  reg         wr = 1'b0;                 // write
  reg         rd = 1'b0;                 // read
  reg         ext_conv_trigger_n = 1'b1; // trigger pin
  reg  [79:0] ch_level = 80'h0;          // channel levels
  reg  [19:0] exp_level = 20'h0;         // expansion levels
  reg  [15:0] d;                         // read value
  reg  [15:0] ctl_w;                     // control word
  reg  [9:0]  lv;                        // corner level
  reg  [2:0]  ch;                        // channel
  reg  [1:0]  rt;                        // route
  reg         xs;                        // pin select
  wire [15:0] rdata;                     // read data
  wire [9:0]  dac_code;                  // trial code
  wire [2:0]  analog_channel_sel;        // channel
  wire        comp_out;                  // decision
  wire        sample;                    // sampling
  wire        expansion_input_sel;       // pin select
  wire        expansion_input_0_out;     // channel out
  wire        convert_expansion;         // pin convert
  wire        irq;                       // interrupt
  integer     n_fail = 0;                // mismatches
  integer     comparisons = 0;           // compares
  integer     i;                         // loop
  integer     k;                         // wait

  always #2 clk = ~clk;

  adc_one_shot_sequencer #(.RES_BITS(10)) i_dut (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ext_conv_trigger_n(ext_conv_trigger_n), .comp_out(comp_out),
    .dac_code(dac_code), .sample(sample), .analog_channel_sel(analog_channel_sel),
    .expansion_input_sel(expansion_input_sel), .irq(irq),
    .expansion_input_0_out(expansion_input_0_out), .convert_expansion(convert_expansion));
  adc_comparator_model i_cmp (
    .ch_level(ch_level), .exp_level(exp_level), .analog_channel_sel(analog_channel_sel),
    .expansion_input_sel(expansion_input_sel), .comp_out(comp_out), .dac_code(dac_code),
    .expansion_input_0_out(expansion_input_0_out), .convert_expansion(convert_expansion));

  task check(input [15:0] got, input [15:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wr_reg(input [3:0] a, input [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input [3:0] a, output [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task wait_irq;
    for (k = 0; k < 2000 && irq !== 1'b1; k = k + 1)
      @(posedge clk) #1;
    check({15'h0, irq}, 16'h0001);
  endtask
  task clr_irq;
    wr_reg(`ADDR_INT_STATUS, 16'h0003);
    #1 check({15'h0, irq}, 16'h0000);
  endtask
  task trig;
    @(posedge clk);
    ext_conv_trigger_n <= 1'b1;
    repeat (3) @(posedge clk);
    ext_conv_trigger_n <= 1'b0;
  endtask
  // expected result word, eight bit mode drops the two low bits
  function [15:0] expv(input [1:0] r, input [2:0] c, input x, input r10);
    reg [9:0] v;
    v = (r == `ROUTE_EXPANSION) ? (x ? exp_level[19:10] : exp_level[9:0])
                                : ch_level[c*10 +: 10];
    if (!r10)
      v[1:0] = 2'b00;
    expv = {6'h00, v};
  endfunction
  task res_chk(input [1:0] r, input [2:0] c, input x, input r10);
    rd_reg((r == `ROUTE_EXPANSION) ? `ADDR_EXP_RESULT : `ADDR_RESULT_BASE + {1'b0, c}, d);
    check(d, expv(r, c, x, r10));
  endtask
  task tally_and_finish;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog
  initial begin
    #100000;
    n_fail = n_fail + 1;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish;
  end

  // main sequence
  initial begin
    d = 16'($urandom(32'h7606da51));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd_reg(`ADDR_CONTROL, d);
    check(d, {4'h0, `CONTROL_RESET});
    rd_reg(4'h5, d);
    check(d, 16'h0000);
    wr_reg(`ADDR_INT_MASK, 16'h0001);
    // every clock, resolution, hold and route with random levels
    for (i = 0; i < 12; i = i + 1) begin
      ch = 3'($urandom);
      xs = 1'($urandom);
      rt = 2'((i + i / 3) % 3);
      lv = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : 10'($urandom);
      wr_reg(`ADDR_CONTROL, 16'h0000);
      ch_level[ch*10 +: 10] <= lv;
      exp_level <= 20'($urandom);
      ctl_w = {4'h0, xs, rt, 2'(i % 3), ch, i >= 6, 1'(i / 3), 2'b01};
      wr_reg(`ADDR_CONTROL, ctl_w);
      wait_irq;
      res_chk(rt, ch, xs, ctl_w[2]);
      rd_reg(`ADDR_INT_STATUS, d);
      check(d, 16'h0001);
      rd_reg(`ADDR_CONTROL, d);
      check({15'h0, d[0]}, {15'h0, rt == `ROUTE_AMPLIFIER});
      clr_irq;
    end
    // software abort, then mask handling of the abort flag
    rd_reg(`ADDR_RESULT_BASE + 4'h5, d);
    ch_level[59:50] <= ~ch_level[59:50];
    wr_reg(`ADDR_CONTROL, 16'h0055);
    repeat (40) @(posedge clk);
    wr_reg(`ADDR_CONTROL, 16'h0054);
    repeat (300) @(posedge clk);
    rd_reg(`ADDR_INT_STATUS, ctl_w);
    check(ctl_w, 16'h0002);
    rd_reg(`ADDR_RESULT_BASE + 4'h5, ctl_w);
    check(ctl_w, d);
    wr_reg(`ADDR_INT_MASK, 16'h0003);
    #1 check({15'h0, irq}, 16'h0001);
    wr_reg(`ADDR_INT_MASK, 16'h0000);
    #1 check({15'h0, irq}, 16'h0000);
    wr_reg(`ADDR_INT_MASK, 16'h0001);
    clr_irq;
    // external trigger: arm, repeat, restart mid-conversion
    wr_reg(`ADDR_CONTROL, 16'h013f);
    repeat (20) @(posedge clk);
    check({15'h0, sample}, 16'h0000);
    for (i = 0; i < 3; i = i + 1) begin
      ch_level[39:30] <= 10'($urandom);
      trig;
      if (i == 2) begin
        repeat (12) @(posedge clk);
        ch_level[39:30] <= 10'($urandom);
        trig;
      end
      wait_irq;
      res_chk(`ROUTE_CHANNEL, 3'd3, 1'b0, 1'b1);
      clr_irq;
    end
    tally_and_finish;
  end
endmodule
